// File: rtl/odc_consts.svh
// constants of the display command decoder: opcodes, reset values, status bits
// assumes byte-wide host transfers
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH

// opcodes
`define ODC_OP_COL_WINDOW   8'h15
`define ODC_OP_RAM_WRITE    8'h5C
`define ODC_OP_RAM_READ     8'h5D
`define ODC_OP_ROW_WINDOW   8'h75
`define ODC_OP_CONTRAST_A   8'h81
`define ODC_OP_CONTRAST_B   8'h82
`define ODC_OP_CONTRAST_C   8'h83
`define ODC_OP_MASTER_CUR   8'h87

// reset values
`define ODC_RST_COL_START   8'h00
`define ODC_RST_COL_END     8'h9F
`define ODC_RST_ROW_START   8'h00
`define ODC_RST_ROW_END     8'h83
`define ODC_RST_CONTRAST    8'h80
`define ODC_RST_MASTER_CUR  4'hF

// master current field position in its parameter byte
`define ODC_MC_MSB          3
`define ODC_MC_LSB          0

// status byte bit positions (read with data/command low)
`define ODC_STAT_WRITE_BIT  0
`define ODC_STAT_READ_BIT   1
`define ODC_STAT_PEND_BIT   2

`endif

// File: rtl/odc_pkg.sv
// types shared by the display command decoder and its address walker
// assumes nothing beyond SystemVerilog packages
package odc_pkg;

  typedef logic [7:0] odc_byte_t;

  typedef enum logic [2:0] {
    ODC_ST_OPCODE = 3'b001,
    ODC_ST_ARG0   = 3'b010,
    ODC_ST_ARG1   = 3'b100
  } odc_state_t;

  typedef enum logic [2:0] {
    ODC_ACC_NONE  = 3'b001,
    ODC_ACC_WRITE = 3'b010,
    ODC_ACC_READ  = 3'b100
  } odc_access_t;

endpackage

// File: rtl/odc_walk_if.sv
// carrier between the command decoder and the RAM address walker
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none

interface odc_walk_if;
  logic [7:0] col_start;
  logic [7:0] col_end;
  logic [7:0] row_start;
  logic [7:0] row_end;
  logic       load;
  logic       step;
  logic [7:0] col_ptr;
  logic [7:0] row_ptr;

  modport ctrl (output col_start, col_end, row_start, row_end, load, step,
                input  col_ptr, row_ptr);
  modport walk (input  col_start, col_end, row_start, row_end, load, step,
                output col_ptr, row_ptr);
endinterface

`default_nettype wire

// File: rtl/odc_addr_walk.sv
// RAM address walker: column and row pointers inside the access window
// assumes load and step are never high together
`timescale 1ns/10ps
`default_nettype none
`include "odc_consts.svh"

module odc_addr_walk (
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  // window and pointers
  odc_walk_if.walk   walk
);
  import odc_pkg::*;

  logic [7:0] col_q;
  logic [7:0] row_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      col_q <= `ODC_RST_COL_START;
      row_q <= `ODC_RST_ROW_START;
    end
    else if (walk.load)
    begin
      col_q <= walk.col_start;
      row_q <= walk.row_start;
    end
    else if (walk.step)
    begin
      if (col_q == walk.col_end)
      begin
        col_q <= walk.col_start;
        // past the last row the window starts over
        if (row_q == walk.row_end)
          row_q <= walk.row_start;
        else
          row_q <= row_q + 8'h01;
      end
      else
      begin
        col_q <= col_q + 8'h01;
      end
    end
  end

  assign walk.col_ptr = col_q;
  assign walk.row_ptr = row_q;

endmodule

`default_nettype wire

// File: rtl/odc_cmd_decoder.sv
// command decoder of a colour passive-matrix display controller
// assumes one-cycle host strobes synchronous to i_clk, never both at once
//
// Operation
// - data/command low marks an opcode byte, high a parameter or pixel byte
// - opcode 15h takes start then end column of the RAM window
// - column window resets to 0 through 159
// - opcode 75h takes start then end row of the RAM window
// - row window resets to 0 through 131
// - opcode 5Ch makes following data bytes write display RAM
// - opcode 5Dh makes following data reads return display RAM
// - opcode 81h sets colour A contrast, reset 80h
// - opcode 82h sets colour B contrast, reset 80h
// - opcode 83h sets colour C contrast, reset 80h
// - opcode 87h sets 4-bit master current, reset 0Fh
// - master current uses only the low four parameter bits
`timescale 1ns/10ps
`default_nettype none
`include "odc_consts.svh"

module odc_cmd_decoder #(
  parameter int unsigned COLS = 160,
  parameter int unsigned ROWS = 132
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // host byte port
  input  wire logic        i_dc,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  input  wire odc_pkg::odc_byte_t i_wdata,
  output odc_pkg::odc_byte_t o_rdata,
  // segment drive settings
  output odc_pkg::odc_byte_t o_colour_a_contrast,
  output odc_pkg::odc_byte_t o_colour_b_contrast,
  output odc_pkg::odc_byte_t o_colour_c_contrast,
  output logic [3:0]       o_master_current,
  // access window
  output odc_pkg::odc_byte_t o_col_start,
  output odc_pkg::odc_byte_t o_col_end,
  output odc_pkg::odc_byte_t o_row_start,
  output odc_pkg::odc_byte_t o_row_end,
  // access state
  output logic             o_ram_write_mode,
  output logic             o_ram_read_mode,
  output odc_pkg::odc_byte_t o_col_ptr,
  output odc_pkg::odc_byte_t o_row_ptr
);
  import odc_pkg::*;

  // one byte per pointer position, whatever the colour format of the stream
  localparam int unsigned DEPTH  = COLS * ROWS;
  localparam int unsigned ADDR_W = $clog2(DEPTH);

  odc_state_t  state_q;
  odc_access_t acc_q;
  odc_byte_t   op_q;
  odc_byte_t   arg0_q;

  odc_byte_t   col_start_q;
  odc_byte_t   col_end_q;
  odc_byte_t   row_start_q;
  odc_byte_t   row_end_q;

  odc_byte_t   con_a_q;
  odc_byte_t   con_b_q;
  odc_byte_t   con_c_q;
  logic [3:0]  mcur_q;
  odc_byte_t   rdata_q;
  logic        two_arg_q;

  logic        cmd_byte;
  logic        arg_byte;
  logic        pix_wr;
  logic        pix_rd;
  logic        col_done;
  logic        row_done;
  logic        in_range;
  logic        op_one_arg;
  logic        op_two_arg;
  logic        arg0_byte;
  logic        acc_open;
  logic        win_done;
  logic        col_in_range;
  logic        row_in_range;
  logic [ADDR_W-1:0] ram_addr;
  odc_byte_t   status;

  odc_byte_t   ram [DEPTH];

  odc_walk_if  wlk ();

  // byte classification
  assign cmd_byte = i_wr_stb & ~i_dc;
  assign arg_byte = i_wr_stb & i_dc & (state_q != ODC_ST_OPCODE);
  // pixel bytes only count once every parameter has been taken
  assign pix_wr   = i_wr_stb & i_dc & (state_q == ODC_ST_OPCODE)
                    & (acc_q == ODC_ACC_WRITE);
  assign pix_rd   = i_rd_stb & i_dc & (acc_q == ODC_ACC_READ);
  assign arg0_byte = arg_byte & (state_q == ODC_ST_ARG0);

  // parameter count per opcode; unknown opcodes take none
  always_comb
  begin
    op_one_arg = 1'b0;
    op_two_arg = 1'b0;
    unique case (i_wdata)
      `ODC_OP_COL_WINDOW,
      `ODC_OP_ROW_WINDOW:  op_two_arg = 1'b1;
      `ODC_OP_CONTRAST_A,
      `ODC_OP_CONTRAST_B,
      `ODC_OP_CONTRAST_C,
      `ODC_OP_MASTER_CUR:  op_one_arg = 1'b1;
      default:             op_one_arg = 1'b0;
    endcase
  end

  // parameter sequencing
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= ODC_ST_OPCODE;
    end
    else if (cmd_byte)
    begin
      // an opcode always restarts the count, even mid-parameter
      if (op_one_arg || op_two_arg)
        state_q <= ODC_ST_ARG0;
      else
        state_q <= ODC_ST_OPCODE;
    end
    else if (arg_byte)
    begin
      unique case (state_q)
        ODC_ST_ARG0:
        begin
          if (two_arg_q)
            state_q <= ODC_ST_ARG1;
          else
            state_q <= ODC_ST_OPCODE;
        end
        ODC_ST_ARG1:
        begin
          state_q <= ODC_ST_OPCODE;
        end
        default:
        begin
          state_q <= ODC_ST_OPCODE;
        end
      endcase
    end
  end

  // parameter count of the pending opcode, fixed when the opcode arrives
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      two_arg_q <= 1'b0;
    else if (cmd_byte)
      two_arg_q <= op_two_arg;
  end

  // opcode whose parameters are being taken
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      op_q <= 8'h00;
    else if (cmd_byte)
      op_q <= i_wdata;
  end

  // first of two parameters is parked until the second arrives
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      arg0_q <= 8'h00;
    else if (arg0_byte)
      arg0_q <= i_wdata;
  end

  assign col_done = arg_byte && state_q == ODC_ST_ARG1
                    && op_q == `ODC_OP_COL_WINDOW;
  assign row_done = arg_byte && state_q == ODC_ST_ARG1
                    && op_q == `ODC_OP_ROW_WINDOW;

  // column window, applied only when both bytes are in
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      col_start_q <= `ODC_RST_COL_START;
    else if (col_done)
      col_start_q <= arg0_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      col_end_q <= `ODC_RST_COL_END;
    else if (col_done)
      col_end_q <= i_wdata;
  end

  // row window, applied only when both bytes are in
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      row_start_q <= `ODC_RST_ROW_START;
    else if (row_done)
      row_start_q <= arg0_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      row_end_q <= `ODC_RST_ROW_END;
    else if (row_done)
      row_end_q <= i_wdata;
  end

  // contrast per colour, each from its single parameter byte
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      con_a_q <= `ODC_RST_CONTRAST;
    else if (arg0_byte && op_q == `ODC_OP_CONTRAST_A)
      con_a_q <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      con_b_q <= `ODC_RST_CONTRAST;
    else if (arg0_byte && op_q == `ODC_OP_CONTRAST_B)
      con_b_q <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      con_c_q <= `ODC_RST_CONTRAST;
    else if (arg0_byte && op_q == `ODC_OP_CONTRAST_C)
      con_c_q <= i_wdata;
  end

  // master current; upper nibble of the parameter is ignored
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      mcur_q <= `ODC_RST_MASTER_CUR;
    else if (arg0_byte && op_q == `ODC_OP_MASTER_CUR)
      mcur_q <= i_wdata[`ODC_MC_MSB:`ODC_MC_LSB];
  end

  // RAM access mode: any other opcode ends a write or read stream
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc_q <= ODC_ACC_NONE;
    end
    else if (cmd_byte)
    begin
      if (i_wdata == `ODC_OP_RAM_WRITE)
        acc_q <= ODC_ACC_WRITE;
      else if (i_wdata == `ODC_OP_RAM_READ)
        acc_q <= ODC_ACC_READ;
      else
        acc_q <= ODC_ACC_NONE;
    end
  end

  // pointer walk
  assign wlk.col_start = col_start_q;
  assign wlk.col_end   = col_end_q;
  assign wlk.row_start = row_start_q;
  assign wlk.row_end   = row_end_q;
  // a new access stream starts at the window origin; a new window loads the origin it replaces
  assign win_done = col_done | row_done;
  assign acc_open = cmd_byte & ((i_wdata == `ODC_OP_RAM_WRITE)
                              | (i_wdata == `ODC_OP_RAM_READ));
  assign wlk.load = win_done | acc_open;
  assign wlk.step = pix_wr | pix_rd;

  odc_addr_walk u_walk (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .walk   (wlk.walk)
  );

  // pointers past the array (window set beyond the panel) are dropped
  assign col_in_range = 32'(wlk.col_ptr) < COLS;
  assign row_in_range = 32'(wlk.row_ptr) < ROWS;
  assign in_range     = col_in_range & row_in_range;
  assign ram_addr = ADDR_W'(32'(wlk.row_ptr) * COLS + 32'(wlk.col_ptr));

  // display RAM has no reset; contents are undefined until written
  always_ff @(posedge i_clk)
  begin
    if (pix_wr && in_range)
      ram[ram_addr] <= i_wdata;
  end

  // status lets the host poll the access mode and a half-sent command
  always_comb
  begin
    status = 8'h00;
    status[`ODC_STAT_WRITE_BIT] = (acc_q == ODC_ACC_WRITE);
    status[`ODC_STAT_READ_BIT]  = (acc_q == ODC_ACC_READ);
    status[`ODC_STAT_PEND_BIT]  = (state_q != ODC_ST_OPCODE);
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= 8'h00;
    else if (pix_rd && in_range)
      rdata_q <= ram[ram_addr];
    else if (i_rd_stb && !i_dc)
      rdata_q <= status;
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata             = rdata_q;
  assign o_colour_a_contrast = con_a_q;
  assign o_colour_b_contrast = con_b_q;
  assign o_colour_c_contrast = con_c_q;
  assign o_master_current    = mcur_q;
  assign o_col_start         = col_start_q;
  assign o_col_end           = col_end_q;
  assign o_row_start         = row_start_q;
  assign o_row_end           = row_end_q;
  assign o_ram_write_mode    = (acc_q == ODC_ACC_WRITE);
  assign o_ram_read_mode     = (acc_q == ODC_ACC_READ);
  assign o_col_ptr           = wlk.col_ptr;
  assign o_row_ptr           = wlk.row_ptr;

endmodule

`default_nettype wire

// File: tb/odc_cmd_decoder_sva.sv
// checker of the display command decoder, watching its top-level ports only
// assumes one clock domain and back-to-back host strobes
`timescale 1ns/10ps
`default_nettype none

module odc_cmd_decoder_sva (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_nrst,
  // host byte port
  input wire logic              i_dc,
  input wire logic              i_wr_stb,
  input wire logic              i_rd_stb,
  input wire odc_pkg::odc_byte_t i_wdata,
  input wire odc_pkg::odc_byte_t o_rdata,
  // settings and access state
  input wire odc_pkg::odc_byte_t o_colour_a_contrast,
  input wire logic [3:0]        o_master_current,
  input wire odc_pkg::odc_byte_t o_col_start,
  input wire odc_pkg::odc_byte_t o_col_end,
  input wire logic              o_ram_write_mode,
  input wire logic              o_ram_read_mode,
  input wire odc_pkg::odc_byte_t o_col_ptr
);
  import odc_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_op(logic [7:0] b);
    i_wr_stb && !i_dc && i_wdata == b;
  endsequence
  logic prm;
  assign prm = i_wr_stb && i_dc;

  AST_RDATA_IDLE: assert property (!i_rd_stb |=> o_rdata == 8'h00)
    else $error("read data outside a read answer");
  AST_COL_WIN: assert property (s_op(8'h15) ##1 prm ##1 prm |=>
    o_col_start == $past(i_wdata, 2) && o_col_end == $past(i_wdata))
    else $error("column window not taken");
  AST_CON_A: assert property (s_op(8'h81) ##1 prm |=>
    o_colour_a_contrast == $past(i_wdata)) else $error("contrast A not taken");
  AST_MASTER: assert property (s_op(8'h87) ##1 prm |=>
    o_master_current == $past(i_wdata[3:0])) else $error("master current wrong");
  AST_WR_MODE: assert property (s_op(8'h5C) |=> o_ram_write_mode && !o_ram_read_mode)
    else $error("write mode not entered");
  AST_RD_MODE: assert property (s_op(8'h5D) |=> o_ram_read_mode && !o_ram_write_mode)
    else $error("read mode not entered");
  AST_PTR_STEP: assert property (o_ram_write_mode && prm && o_col_ptr != o_col_end |=>
    o_col_ptr == 8'($past(o_col_ptr) + 8'h01)) else $error("column pointer did not step");
  AST_HOLD: assert property (!i_wr_stb |=> $stable(o_colour_a_contrast) &&
    $stable(o_col_end) && $stable(o_master_current)) else $error("setting moved");

  COV_COL: cover property (s_op(8'h15) ##1 prm ##1 prm);
  COV_WR: cover property (s_op(8'h5C) ##1 prm);
  COV_RD: cover property (s_op(8'h5D) ##1 i_rd_stb);
endmodule

bind odc_cmd_decoder odc_cmd_decoder_sva i_odc_cmd_decoder_sva (.*);

`default_nettype wire

// File: tb/odc_host_model.sv
// host controller model: streams opcode, parameter and pixel bytes, reads back
// assumes the decoder takes strobes on the rising edge of i_clk
`timescale 1ns/10ps
`default_nettype none

module odc_host_model (
  // clock
  input  wire logic       i_clk,
  // host byte port
  output logic            o_dc,
  output logic            o_wr_stb,
  output logic            o_rd_stb,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata
);
  initial
  begin
    o_dc = 1'b0;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_wdata = 8'h00;
  end

  // strobe stays high so consecutive calls stream on consecutive edges
  task automatic send(input logic dc, input logic [7:0] b);
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    o_wr_stb <= 1'b1;
    o_dc <= dc;
    o_wdata <= b;
  endtask

  task automatic idle();
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_wdata <= ~o_wdata;
    #1;
  endtask

  task automatic get(input logic dc, output logic [7:0] b);
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b1;
    o_dc <= dc;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    #1;
    b = i_rdata;
  endtask
endmodule

`default_nettype wire

// File: tb/tb_oled_display_command_decoder.sv
// testbench of the display command decoder driven through the host model
// assumes default panel size parameters
`timescale 1ns/10ps
`default_nettype none

module tb_oled_display_command_decoder;
  import odc_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_nrst = 1'b0;
  logic       i_dc;
  logic       i_wr_stb;
  logic       i_rd_stb;
  odc_byte_t  i_wdata;
  odc_byte_t  o_rdata, o_colour_a_contrast, o_colour_b_contrast, o_colour_c_contrast;
  odc_byte_t  o_col_start, o_col_end, o_row_start, o_row_end, o_col_ptr, o_row_ptr;
  logic [3:0] o_master_current;
  logic       o_ram_write_mode;
  logic       o_ram_read_mode;
  odc_byte_t  rd;
  odc_byte_t  prm_tbl [3] = '{8'hFF, 8'h5C, 8'h15};
  int         bad_count = 0;
  int         tests_run = 0;

  always #5 i_clk = ~i_clk;

  odc_cmd_decoder i_odc_cmd_decoder (.*);
  odc_host_model host (.i_clk(i_clk), .o_dc(i_dc), .o_wr_stb(i_wr_stb),
    .o_rd_stb(i_rd_stb), .o_wdata(i_wdata), .i_rdata(o_rdata));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    chk(o_col_start, 8'h00);
    chk(o_col_end, 8'h9F);
    chk(o_row_start, 8'h00);
    chk(o_row_end, 8'h83);
    chk(o_colour_a_contrast, 8'h80);
    chk(o_colour_b_contrast, 8'h80);
    chk(o_colour_c_contrast, 8'h80);
    chk({4'h0, o_master_current}, 8'h0F);
  endtask

  initial
  begin
    do_reset();
    // parameters that look like opcodes must still land as parameters
    for (int k = 0; k < 3; k++)
    begin
      host.send(1'b0, 8'h81 + 8'(k));
      host.send(1'b1, prm_tbl[k]);
    end
    host.send(1'b0, 8'h87);
    host.send(1'b1, 8'hF3);
    host.idle();
    chk(o_colour_a_contrast, 8'hFF);
    chk(o_colour_b_contrast, 8'h5C);
    chk(o_colour_c_contrast, 8'h15);
    chk({4'h0, o_master_current}, 8'h03);
    chk({7'h00, o_ram_write_mode}, 8'h00);
    host.send(1'b0, 8'h15);
    host.send(1'b1, 8'h10);
    host.send(1'b0, 8'h81);
    host.send(1'b1, 8'h00);
    host.idle();
    chk(o_col_start, 8'h00);
    chk(o_col_end, 8'h9F);
    chk(o_colour_a_contrast, 8'h00);
    host.send(1'b0, 8'h15);
    host.send(1'b1, 8'h02);
    host.send(1'b1, 8'h03);
    host.send(1'b0, 8'h75);
    host.send(1'b1, 8'h01);
    host.send(1'b1, 8'h02);
    host.send(1'b0, 8'h5C);
    host.idle();
    chk(o_col_start, 8'h02);
    chk(o_col_end, 8'h03);
    chk(o_row_start, 8'h01);
    chk(o_row_end, 8'h02);
    chk({o_col_ptr[3:0], o_row_ptr[3:0]}, 8'h21);
    chk({7'h00, o_ram_write_mode}, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      host.send(1'b1, 8'hA0 + 8'(k));
      host.idle();
      chk(o_col_ptr, 8'h02 + 8'((k + 1) % 2));
      chk(o_row_ptr, 8'h01 + 8'(((k + 1) / 2) % 2));
    end
    host.get(1'b0, rd);
    chk(rd, 8'h01);
    host.send(1'b0, 8'h5D);
    for (int k = 0; k < 4; k++)
    begin
      host.get(1'b1, rd);
      chk(rd, 8'hA0 + 8'(k));
    end
    host.get(1'b0, rd);
    chk(rd, 8'h02);
    chk({7'h00, o_ram_read_mode}, 8'h01);
    // a half-sent window command shows as pending and closes the read stream
    host.send(1'b0, 8'h75);
    host.get(1'b0, rd);
    chk(rd, 8'h04);
    chk({7'h00, o_ram_read_mode}, 8'h00);
    host.get(1'b1, rd);
    chk(rd, 8'h00);
    chk(o_row_end, 8'h02);
    do_reset();
    print_verdict();
  end

  // the sequence needs under sixty cycles; some thirty-five times that cuts a hang
  initial
  begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
